/* File: core/tsp_pkg.sv */
// How it works
// RULE1: read returns pointed register, high byte first
// RULE2: master nack, start or stop ends sending
// RULE3: acknowledge alert response, return own address
// RULE4: returned last bit shows over-limit cause
// RULE5: bitwise arbitration, winner drops its alert; with THERM_BIT or DR_MODE_BIT set the code leaves its alert asserted
// RULE6: arbitration loser keeps alert and flags
// RULE7: acknowledge general call, next byte command
// RULE8: reset command reloads all registers
// RULE9: stuck clock or data low resets interface
// RULE10: after timeout release data, await start
// RULE11: master keeps clock at 1 kHz or faster
// RULE12: start is data fall while clock high
// RULE13: stop is data rise while clock high
// RULE14: no limit on bytes per transfer
// RULE15: receiver holds data low during ack
// RULE16: temperature result is read-only 16-bit value
// RULE17: result reads 8000h until first conversion
// RULE18: backed registers reload from nonvolatile image
// RULE19: pointer kept until next write, resets zero
// RULE20: address 10010xx, low bits from select pin
// RULE21: over-limit flag set, cleared by setup read; with THERM_BIT set the code clears it only when below the lower limit
// RULE22: bad writes ignored, unmapped reads zero
// RULE23: general reset clears pointer and alert
package tsp_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TIMEOUT_MS = 35;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned SCL_HZ = 100_000;
  localparam int unsigned SCL_MIN_HZ = 1000;
  localparam int unsigned SCL_HALF_CYC = CLK_HZ / (2 * SCL_HZ);
  localparam logic [4:0] ADDR_BASE = 5'h12;
  localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  localparam logic [7:0] ARA_CMD = 8'h19;
  localparam logic [7:0] PTR_TEMP = 8'h00;
  localparam logic [7:0] PTR_SETUP = 8'h01;
  localparam logic [7:0] PTR_UPPER = 8'h02;
  localparam logic [7:0] PTR_LOWER = 8'h03;
  localparam logic [7:0] PTR_RW_LAST = 8'h08;
  localparam logic [7:0] PTR_ID = 8'h0F;
  localparam logic [15:0] TEMP_RST = 16'h8000;
  localparam int unsigned SOFT_RST_BIT = 1;
  localparam int unsigned DR_MODE_BIT = 2;
  localparam int unsigned POL_BIT = 3;
  localparam int unsigned THERM_BIT = 4;
  localparam int unsigned NV_W = 128;
  localparam logic [15:0] RW_RST [1:8] = '{16'h0220, 16'h6000, 16'h8000, 16'h0000,
                                            16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] RW_WMASK [1:8] = '{16'h0FFC, 16'hFFFF, 16'hFFFF, 16'hFFFF,
                                              16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
  localparam logic [8:1] NV_MASK = 8'hF7;
  localparam logic [7:0] HR_CMD = 8'h00;
  localparam logic [7:0] HR_DATA = 8'h04;
  localparam logic [7:0] HR_STAT = 8'h08;
  localparam int unsigned CMD_ADDR_LSB = 8;
  localparam int unsigned CMD_PTR_LSB = 16;
  typedef enum logic [2:0] {OP_PTR, OP_WRITE, OP_READ, OP_GC, OP_ALERT} tsp_op_e;
endpackage

/* File: core/tsp_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface tsp_if;
  logic m_scl_out;
  logic m_scl_oe;
  logic m_sda_out;
  logic m_sda_oe;
  logic s_sda_out;
  logic s_sda_oe;
  logic s_alert;
  logic scl;
  logic sda;
  // open drain: any enabled low driver wins, else pulled up
  assign scl = !(m_scl_oe && !m_scl_out);
  assign sda = !((m_sda_oe && !m_sda_out) || (s_sda_oe && !s_sda_out));
  modport dev (input scl, input sda, output s_sda_out, output s_sda_oe, output s_alert);
  modport host (input scl, input sda, input s_alert, output m_scl_out, output m_scl_oe,
                output m_sda_out, output m_sda_oe);
endinterface
`default_nettype wire

/* File: core/tsp_dev.sv */
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module tsp_dev #(
  parameter int unsigned TIMEOUT_CYC = tsp_pkg::TIMEOUT_CYC,
  parameter logic [15:0] PART_ID = 16'h5A3C // arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  tsp_if.dev bus,
  input wire logic [1:0] i_addr_sel,
  input wire logic [15:0] i_temp_data,
  input wire logic i_temp_valid,
  input wire logic [tsp_pkg::NV_W-1:0] i_nv_image
);
  import tsp_pkg::*;
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} tsp_st_e;
  typedef enum logic [1:0] {MD_WR, MD_RD, MD_GC, MD_ARA} tsp_md_e;

  // ****************
  // pin sampling
  // ****************
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic [1:0] asel_sync_reg [0:1];
  logic scl_prev_reg;
  logic sda_prev_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      asel_sync_reg <= '{2'h0, 2'h0};
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      asel_sync_reg <= '{i_addr_sel, asel_sync_reg[0]};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end
  wire scl_s = scl_sync_reg[1];
  wire sda_s = sda_sync_reg[1];
  wire scl_rise = scl_s && !scl_prev_reg;
  wire scl_fall = !scl_s && scl_prev_reg;
  wire both_hi = scl_s && scl_prev_reg;
  wire start_det = both_hi && sda_prev_reg && !sda_s; // [RULE12]
  wire stop_det = both_hi && !sda_prev_reg && sda_s; // [RULE13]
  wire [6:0] my_addr = {ADDR_BASE, asel_sync_reg[1]}; // [RULE20]

  // ****************
  // state
  // ****************
  tsp_st_e st_reg;
  tsp_md_e md_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  logic [7:0] lo_byte_reg;
  logic [7:0] hi_byte_reg;
  logic first_reg;
  logic ptrph_reg;
  logic lo_reg;
  logic sda_low_reg;
  logic busy_reg;
  logic [31:0] to_cnt_reg;
  logic [7:0] ptr_reg;
  logic [15:0] temp_reg;
  logic [15:0] rw_reg [1:8];
  logic hi_flag_reg;
  logic lo_flag_reg;
  logic dr_flag_reg;
  logic reload_reg;
  logic alert_reg;

  wire [15:0] setup = rw_reg[1];
  wire therm = setup[THERM_BIT];
  wire alert_src = setup[DR_MODE_BIT] ? dr_flag_reg : (hi_flag_reg || lo_flag_reg);
  wire addr_hit = sh_reg[7:1] == my_addr;
  wire gc_hit = sh_reg == GC_ADDR_BYTE; // [RULE7]
  wire ara_hit = (sh_reg == ARA_CMD) && alert_src; // [RULE3]
  wire ack_dec = first_reg ? (addr_hit || gc_hit || ara_hit) : 1'b1; // [RULE22]
  wire tsp_md_e md_dec = addr_hit ? (sh_reg[0] ? MD_RD : MD_WR) : (gc_hit ? MD_GC : MD_ARA);
  wire byte_end = (st_reg == ST_RX) && scl_fall && (cnt_reg == 4'h8);
  wire wr_ptr = byte_end && !first_reg && (md_reg == MD_WR) && ptrph_reg; // [RULE19]
  wire wr_data = byte_end && !first_reg && (md_reg == MD_WR) && !ptrph_reg;
  wire wr_word = wr_data && lo_reg;
  wire gc_rst = byte_end && !first_reg && (md_reg == MD_GC) && (sh_reg == GC_RESET_CMD); // [RULE8]
  wire soft_rst = wr_word && (ptr_reg == PTR_SETUP) && sh_reg[SOFT_RST_BIT];
  wire sending = (md_reg == MD_RD) || (md_reg == MD_ARA);
  wire m_ack = scl_rise && !sda_s;
  wire tx_load = ((st_reg == ST_RX_ACK) && scl_fall && sending) ||
                 ((st_reg == ST_TX_ACK) && m_ack && (md_reg == MD_RD));
  wire rd_evt = tx_load && (md_reg == MD_RD) && !lo_reg;
  wire setup_rd = rd_evt && (ptr_reg == PTR_SETUP);
  wire ara_done = (st_reg == ST_TX_ACK) && scl_rise && (md_reg == MD_ARA); // [RULE5]
  wire in_rw = (ptr_reg >= PTR_SETUP) && (ptr_reg <= PTR_RW_LAST);
  wire [15:0] setup_rd_val = {hi_flag_reg, lo_flag_reg, dr_flag_reg, 1'b0, setup[11:0]};
  wire [15:0] rd_word = (ptr_reg == PTR_TEMP) ? temp_reg :
                        (ptr_reg == PTR_SETUP) ? setup_rd_val :
                        in_rw ? rw_reg[ptr_reg[3:0]] :
                        (ptr_reg == PTR_ID) ? PART_ID : 16'h0000; // [RULE22] [RULE1]
  wire [7:0] ara_byte = {my_addr, hi_flag_reg}; // [RULE4]
  wire [7:0] tx_next = (md_reg == MD_ARA) ? ara_byte : (lo_reg ? lo_byte_reg : rd_word[15:8]);
  wire tx_bit = tx_reg[3'(4'h7 - cnt_reg)];
  // only a bit being sent can lose; a mode left over must not cut the next transfer
  wire lost = (md_reg == MD_ARA) && (st_reg == ST_TX) && scl_rise &&
              !sda_low_reg && !sda_s; // [RULE6]
  wire to_hit = to_cnt_reg == 32'(TIMEOUT_CYC - 1);
  wire to_fire = to_hit && !scl_s; // [RULE10]

  // ****************
  // transfer engine
  // ****************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= ST_IDLE;
      md_reg <= MD_WR;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      first_reg <= 1'b0;
      ptrph_reg <= 1'b0;
      lo_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else if (start_det) begin
      st_reg <= ST_RX; // [RULE12]
      cnt_reg <= 4'h0;
      first_reg <= 1'b1;
      sda_low_reg <= 1'b0;
    end else if (stop_det || to_fire || lost) begin
      st_reg <= ST_IDLE; // [RULE13] [RULE9] [RULE5]
      sda_low_reg <= 1'b0;
    end else begin
      case (st_reg)
        ST_RX: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_s};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (byte_end) begin
            first_reg <= 1'b0;
            cnt_reg <= 4'h0;
            st_reg <= ack_dec ? ST_RX_ACK : ST_IDLE;
            sda_low_reg <= ack_dec; // [RULE15]
            if (first_reg) begin
              md_reg <= md_dec;
              ptrph_reg <= 1'b1;
              lo_reg <= 1'b0;
            end else if (md_reg == MD_WR) begin
              ptrph_reg <= 1'b0;
              lo_reg <= ptrph_reg ? 1'b0 : !lo_reg; // [RULE14]
            end
          end
        end
        ST_RX_ACK: begin
          if (scl_fall) begin
            cnt_reg <= 4'h0;
            st_reg <= sending ? ST_TX : ST_RX;
            sda_low_reg <= sending && !tx_next[7];
            if (sending) begin
              tx_reg <= tx_next;
              lo_reg <= 1'b1;
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall) begin
            st_reg <= (cnt_reg == 4'h8) ? ST_TX_ACK : ST_TX;
            sda_low_reg <= (cnt_reg != 4'h8) && !tx_bit;
          end
        end
        ST_TX_ACK: begin
          if (tx_load) begin
            st_reg <= ST_TX; // [RULE14]
            cnt_reg <= 4'h0;
            tx_reg <= tx_next;
            lo_reg <= !lo_reg;
          end else if (scl_rise) begin
            st_reg <= ST_IDLE; // [RULE2]
          end
        end
        ST_IDLE: begin
          sda_low_reg <= 1'b0;
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************
  // timeout and side registers
  // ****************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy_reg <= 1'b0;
      to_cnt_reg <= 32'h0;
      lo_byte_reg <= 8'h00;
      hi_byte_reg <= 8'h00;
      reload_reg <= 1'b1;
      ptr_reg <= PTR_TEMP;
      alert_reg <= 1'b1;
    end else begin
      busy_reg <= start_det || (busy_reg && !stop_det && !to_fire);
      // saturate so release can wait for clock low
      if (!busy_reg || start_det || (scl_s && !sda_low_reg)) begin
        to_cnt_reg <= 32'h0;
      end else if (!to_hit) begin
        to_cnt_reg <= to_cnt_reg + 32'h1; // [RULE9]
      end
      if (rd_evt) begin
        lo_byte_reg <= rd_word[7:0];
      end
      if (wr_data && !lo_reg) begin
        hi_byte_reg <= sh_reg;
      end
      reload_reg <= gc_rst || soft_rst;
      if (reload_reg) begin
        ptr_reg <= PTR_TEMP; // [RULE23]
      end else if (wr_ptr) begin
        ptr_reg <= sh_reg; // [RULE19]
      end
      alert_reg <= setup[POL_BIT] ? alert_src : !alert_src;
    end
  end
  assign bus.s_sda_out = 1'b0;
  assign bus.s_sda_oe = sda_low_reg;
  assign bus.s_alert = alert_reg;

  // ****************
  // register file
  // ****************
  genvar gi;
  for (gi = 1; gi <= 8; gi++) begin : g_rw
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        rw_reg[gi] <= RW_RST[gi];
      end else if (reload_reg) begin
        rw_reg[gi] <= NV_MASK[gi] ? (i_nv_image[gi*16-1 -: 16] & RW_WMASK[gi]) :
                      RW_RST[gi]; // [RULE18] [RULE8]
      end else if (wr_word && (ptr_reg == 8'(gi))) begin
        rw_reg[gi] <= {hi_byte_reg, sh_reg} & RW_WMASK[gi]; // [RULE22]
      end
    end
  end

  wire [15:0] upper = rw_reg[PTR_UPPER[3:0]];
  wire [15:0] lower = rw_reg[PTR_LOWER[3:0]];
  wire hi_set = i_temp_valid && ($signed(i_temp_data) > $signed(upper));
  wire below = i_temp_valid && ($signed(i_temp_data) < $signed(lower));
  wire lo_set = below && !therm;
  wire hi_clr = therm ? below : (setup_rd || ara_done);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      temp_reg <= TEMP_RST;
      hi_flag_reg <= 1'b0;
      lo_flag_reg <= 1'b0;
      dr_flag_reg <= 1'b0;
    end else if (reload_reg) begin
      temp_reg <= TEMP_RST; // [RULE17] [RULE23]
      hi_flag_reg <= 1'b0;
      lo_flag_reg <= 1'b0;
      dr_flag_reg <= 1'b0;
    end else begin
      if (i_temp_valid) begin
        temp_reg <= i_temp_data; // [RULE16]
      end
      // a new event beats a clear in the same cycle
      hi_flag_reg <= hi_set || (hi_flag_reg && !hi_clr); // [RULE21] [RULE5]
      lo_flag_reg <= lo_set || (lo_flag_reg && !setup_rd && !ara_done && !therm);
      dr_flag_reg <= i_temp_valid ||
                     (dr_flag_reg && !(rd_evt && (ptr_reg <= PTR_SETUP)));
    end
  end
endmodule
`default_nettype wire

/* File: core/tsp_host.sv */
`timescale 1ns/10ps
`default_nettype none
module tsp_host #(
  parameter int unsigned HALF_CYC = tsp_pkg::SCL_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  tsp_if.host bus,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);
  import tsp_pkg::*;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} tsp_hst_e;

  // ****************
  // command registers
  // ****************
  tsp_hst_e hst_reg;
  tsp_op_e op_reg;
  logic [6:0] addr_reg;
  logic [7:0] ptr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic nack_reg;
  logic [1:0] step_reg;
  logic [15:0] tick_reg;
  logic [1:0] bi_reg;
  logic [3:0] bit_reg;
  logic ph_reg;
  logic scl_low_reg;
  logic sda_low_reg;
  logic [1:0] sda_sync_reg;

  wire busy = hst_reg != H_IDLE;
  wire go = i_wr && (i_addr == HR_CMD) && !busy;
  // clock half period fixed by divider, well above the slowest allowed rate
  wire tick = tick_reg == 16'(HALF_CYC - 1); // [RULE11]
  wire mid = tick_reg == 16'(HALF_CYC / 2);
  wire sda_s = sda_sync_reg[1];
  wire [1:0] nb_m1 = (op_reg == OP_WRITE) ? 2'h3 : ((op_reg == OP_READ) ? 2'h2 : 2'h1);
  wire b_last = bi_reg == nb_m1;
  wire b_rx = ((op_reg == OP_READ) && (bi_reg != 2'h0)) || ((op_reg == OP_ALERT) && (bi_reg == 2'h1));
  wire [7:0] b0 = (op_reg == OP_GC) ? GC_ADDR_BYTE :
                  (op_reg == OP_ALERT) ? ARA_CMD : {addr_reg, op_reg == OP_READ}; // [RULE3]
  wire [7:0] b1 = (op_reg == OP_GC) ? GC_RESET_CMD : ptr_reg;
  wire [7:0] b_tx = (bi_reg == 2'h0) ? b0 : (bi_reg == 2'h1) ? b1 :
                    (bi_reg == 2'h2) ? wdata_reg[15:8] : wdata_reg[7:0];
  wire data_slot = bit_reg != 4'h8;
  // nack after the last read byte ends the read
  wire want_low = data_slot ? (!b_rx && !b_tx[3'(4'h7 - bit_reg)]) : (b_rx && !b_last); // [RULE2] [RULE15]

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sda_sync_reg <= 2'h3;
      tick_reg <= 16'h0;
      wdata_reg <= 16'h0000;
      o_rdata <= 32'h0;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      tick_reg <= (go || tick || !busy) ? 16'h0 : tick_reg + 16'h1;
      if (i_wr && (i_addr == HR_DATA)) begin
        wdata_reg <= i_wdata[15:0];
      end
      o_rdata <= !i_rd ? 32'h0 : (i_addr == HR_DATA) ? {16'h0000, rdata_reg} :
                 (i_addr == HR_STAT) ? {30'h0, nack_reg, busy} : 32'h0;
    end
  end

  // ****************
  // bus sequencer
  // ****************
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hst_reg <= H_IDLE;
      op_reg <= OP_PTR;
      addr_reg <= 7'h00;
      ptr_reg <= 8'h00;
      rdata_reg <= 16'h0000;
      nack_reg <= 1'b0;
      step_reg <= 2'h0;
      bi_reg <= 2'h0;
      bit_reg <= 4'h0;
      ph_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else if (go) begin
      hst_reg <= H_START;
      op_reg <= tsp_op_e'(i_wdata[2:0]);
      addr_reg <= i_wdata[CMD_ADDR_LSB +: 7];
      ptr_reg <= i_wdata[CMD_PTR_LSB +: 8];
      nack_reg <= 1'b0;
      step_reg <= 2'h0;
    end else begin
      case (hst_reg)
        H_START: begin
          if (tick) begin
            step_reg <= 2'h1;
            sda_low_reg <= 1'b1; // [RULE12]
            scl_low_reg <= step_reg == 2'h1;
            hst_reg <= (step_reg == 2'h1) ? H_BIT : H_START;
            bi_reg <= 2'h0;
            bit_reg <= 4'h0;
            ph_reg <= 1'b0;
          end
        end
        H_BIT: begin
          if (!ph_reg && mid) begin
            sda_low_reg <= want_low;
          end
          if (tick) begin
            ph_reg <= !ph_reg;
            scl_low_reg <= !ph_reg ? 1'b0 : 1'b1;
            if (ph_reg) begin
              bit_reg <= data_slot ? bit_reg + 4'h1 : 4'h0;
              if (data_slot && b_rx) begin
                rdata_reg <= {rdata_reg[14:0], sda_s};
              end
              if (!data_slot) begin
                nack_reg <= nack_reg || (!b_rx && sda_s);
                bi_reg <= bi_reg + 2'h1;
                hst_reg <= ((!b_rx && sda_s) || b_last) ? H_STOP : H_BIT;
                step_reg <= 2'h0;
              end
            end
          end
        end
        H_STOP: begin
          if ((step_reg == 2'h0) && mid) begin
            sda_low_reg <= 1'b1;
          end
          if (tick) begin
            step_reg <= step_reg + 2'h1;
            scl_low_reg <= 1'b0;
            sda_low_reg <= step_reg == 2'h0; // [RULE13]
            hst_reg <= (step_reg == 2'h2) ? H_IDLE : H_STOP;
          end
        end
        default: begin
          hst_reg <= H_IDLE;
        end
      endcase
    end
  end
  assign bus.m_scl_out = 1'b0;
  assign bus.m_scl_oe = scl_low_reg;
  assign bus.m_sda_out = 1'b0;
  assign bus.m_sda_oe = sda_low_reg;
endmodule
`default_nettype wire

/* File: dv/tsp_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module tsp_assertions #(
  parameter int unsigned TIMEOUT_CYC = 2000,
  parameter int unsigned HALF_CYC = 20
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic s_sda_oe,
  input wire logic s_alert,
  input wire logic scl,
  input wire logic sda
);
  // ****************
  // helper logic
  // ****************
  logic scl_q, sda_q, quiet_reg;
  logic [31:0] hold_cnt;
  wire start_ev = scl && scl_q && sda_q && !sda;
  wire stop_ev = scl && scl_q && !sda_q && sda;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      quiet_reg <= 1'b1;
      hold_cnt <= 32'h0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      quiet_reg <= stop_ev ? 1'b1 : (start_ev ? 1'b0 : quiet_reg);
      hold_cnt <= s_sda_oe ? hold_cnt + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // ****************
  // assertions
  // ****************
  a_oe_stable_high: assert property (scl && scl_q |-> $stable(s_sda_oe))
    else $error("device sda enable moved while clock high");
  a_drive_after_fall: assert property ($rose(s_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("device took sda outside clock low");
  a_release_scl_low: assert property ($fell(s_sda_oe) |-> !scl && !$past(scl, 2))
    else $error("device released sda outside clock low");
  a_ack_whole_high: assert property (s_sda_oe && scl && !scl_q |-> s_sda_oe [*3])
    else $error("device dropped low level during high phase");
  a_start_quiet: assert property (start_ev |-> !s_sda_oe [*4])
    else $error("device driving sda around start");
  a_stop_quiet: assert property (quiet_reg |-> !s_sda_oe)
    else $error("device drove sda after stop before start");
  // timeout plus a wait for clock low bounds any hold
  a_stuck_bound: assert property (hold_cnt <= TIMEOUT_CYC + 2 * HALF_CYC + 16)
    else $error("device held sda past timeout");
  a_alert_reset_idle: assert property (!$past(i_arst_n) |-> s_alert)
    else $error("alert active right after reset");
  c_alert_seen: cover property ($fell(s_alert));
endmodule
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tsp_pkg::*;
  localparam int unsigned TO_CYC = 2000;
  localparam int unsigned HC = 20;
  localparam logic [6:0] DEV_ADDR = {ADDR_BASE, 2'b01};
  localparam logic [15:0] NV_UPPER = 16'h4B00;
  logic i_clk, i_arst_n, i_wr, i_rd, i_temp_valid;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata;
  logic [15:0] i_temp_data;
  logic [1:0] addr_sel;
  logic [NV_W-1:0] nv_image;
  int num_errors, comparisons, cyc;
  tsp_if bus_if();
  tsp_dev #(.TIMEOUT_CYC(TO_CYC)) tsp_dev_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .bus(bus_if), .i_addr_sel(addr_sel), .i_temp_data(i_temp_data), .i_temp_valid(i_temp_valid),
    .i_nv_image(nv_image));
  tsp_host #(.HALF_CYC(HC)) tsp_host_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .bus(bus_if),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
  tsp_assertions #(.TIMEOUT_CYC(TO_CYC), .HALF_CYC(HC)) tsp_assertions_inst (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .s_sda_oe(bus_if.s_sda_oe), .s_alert(bus_if.s_alert),
    .scl(bus_if.scl), .sda(bus_if.sda));
  // ****************
  // shared tasks
  // ****************
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic hwr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic hrd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  // polls busy; a hang here ends after 400 polls and fails op_done
  task automatic run_op(input logic [2:0] op, input logic [6:0] addr, input logic [7:0] ptr);
    logic [31:0] w;
    logic [31:0] st;
    int n;
    w = 32'h0;
    w[2:0] = op;
    w[14:8] = addr;
    w[23:16] = ptr;
    hwr(HR_CMD, w);
    st = 32'h1;
    n = 0;
    while (st[0] !== 1'b0 && n < 400) begin
      repeat (8) @(posedge i_clk);
      hrd(HR_STAT, st);
      n++;
    end
    check("op_done", st[0], 1'b0);
  endtask
  task automatic read_word(input logic [7:0] ptr, output logic [31:0] d);
    run_op(OP_PTR, DEV_ADDR, ptr);
    run_op(OP_READ, DEV_ADDR, ptr);
    hrd(HR_DATA, d);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset_values;
    logic [31:0] d;
    check("idle_scl", bus_if.scl, 1'b1);
    check("idle_sda", bus_if.sda, 1'b1);
    read_word(PTR_TEMP, d);
    check("temp_reset", d[15:0], TEMP_RST);
    read_word(PTR_UPPER, d);
    check("upper_nv", d[15:0], NV_UPPER);
    read_word(8'h0A, d);
    check("unmapped_read", d[15:0], 16'h0000);
  endtask
  task automatic t_write_read;
    logic [31:0] d;
    hwr(HR_DATA, 32'h0000_1234);
    run_op(OP_WRITE, DEV_ADDR, PTR_UPPER);
    hrd(HR_STAT, d);
    check("write_acked", d[1], 1'b0);
    run_op(OP_READ, DEV_ADDR, PTR_UPPER);
    hrd(HR_DATA, d);
    check("upper_written", d[15:0], 16'h1234);
    hwr(HR_DATA, 32'h0000_0F0F);
    run_op(OP_WRITE, DEV_ADDR, PTR_TEMP);
    read_word(PTR_TEMP, d);
    check("temp_read_only", d[15:0], TEMP_RST);
  endtask
  task automatic t_general_reset;
    logic [31:0] d;
    hwr(HR_DATA, 32'h0000_1234);
    run_op(OP_WRITE, DEV_ADDR, PTR_UPPER);
    run_op(OP_GC, 7'h00, GC_RESET_CMD);
    run_op(OP_READ, DEV_ADDR, PTR_UPPER);
    hrd(HR_DATA, d);
    check("ptr_cleared", d[15:0], TEMP_RST);
    read_word(PTR_UPPER, d);
    check("upper_reloaded", d[15:0], NV_UPPER);
    hwr(HR_DATA, 32'h0000_1234);
    run_op(OP_WRITE, DEV_ADDR, PTR_UPPER);
    hwr(HR_DATA, 32'h0000_0222);
    run_op(OP_WRITE, DEV_ADDR, PTR_SETUP);
    read_word(PTR_UPPER, d);
    check("upper_soft_reload", d[15:0], NV_UPPER);
  endtask
  task automatic t_alert;
    logic [31:0] d;
    @(posedge i_clk);
    i_temp_data <= 16'h7000;
    i_temp_valid <= 1'b1;
    @(posedge i_clk);
    i_temp_valid <= 1'b0;
    repeat (10) @(posedge i_clk);
    check("alert_low", bus_if.s_alert, 1'b0);
    run_op(OP_ALERT, 7'h0C, ARA_CMD);
    hrd(HR_DATA, d);
    check("alert_reply", d[7:0], {DEV_ADDR, 1'b1});
    check("alert_released", bus_if.s_alert, 1'b1);
    read_word(PTR_TEMP, d);
    check("temp_result", d[15:0], 16'h7000);
  endtask
  task automatic t_other_address;
    logic [31:0] d;
    run_op(OP_READ, {ADDR_BASE, 2'b10}, PTR_TEMP);
    hrd(HR_STAT, d);
    check("foreign_nack", d[1], 1'b1);
    @(posedge i_clk);
    addr_sel <= 2'b10;
    repeat (4) @(posedge i_clk);
    run_op(OP_READ, {ADDR_BASE, 2'b10}, PTR_TEMP);
    hrd(HR_STAT, d);
    check("select_pin_ack", d[1], 1'b0);
  endtask
  // ****************
  // clock, reset, run
  // ****************
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    i_arst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_temp_valid = 1'b0;
    i_temp_data = 16'h0000;
    addr_sel = 2'b01;
    nv_image = '0;
    nv_image[15:0] = 16'h0220;
    nv_image[31:16] = NV_UPPER;
    nv_image[47:32] = 16'h8000;
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    repeat (8) @(posedge i_clk);
    t_reset_values();
    t_write_read();
    t_general_reset();
    t_alert();
    t_other_address();
    give_verdict();
  end
endmodule
`default_nettype wire
